// [src/adc_mode_map.svh]
`ifndef ADC_MODE_MAP_SVH
`define ADC_MODE_MAP_SVH
// register addresses on the serial port
`define ADDR_RESET       7'h00
`define ADDR_POWER       7'h01
`define ADDR_TIMING      7'h02
`define ADDR_DRIVER      7'h03
`define ADDR_FORMAT      7'h04
// reset value of every mode register and the software reset bit
`define REG_RESET_VAL    8'h00
`define SWRST_BIT        7
// writable masks: unused positions are stored and read as zero
`define POWER_MASK       8'h03
`define TIMING_MASK      8'h0F
`define DRIVER_MASK      8'h7F
`define FORMAT_MASK      8'h3F
// serial word layout
`define WORD_BITS        5'd16
`define HEADER_BITS      5'd8
// codes
`define PWR_SLEEP        2'h3
`define DRV_UNUSED       3'h3
`define FMT_UNUSED       2'h3
`define TP_NORMAL        3'h0
`define TP_ZEROS         3'h1
`define TP_ONES          3'h3
`define TP_CHECKER       3'h5
`define TP_ALTERNATE     3'h7
`define CHECKER_A        17'h15555
`define CHECKER_B        17'h0AAAA
`define SIGN_FLIP        16'h8000
// sleep held during a software reset, time then cycles at the clock rate
`define CLK_MHZ          40
`define SWRST_SLEEP_NS   200
`define SWRST_SLEEP_CYC  ((`SWRST_SLEEP_NS * `CLK_MHZ + 999) / 1000)
`endif

// [src/adc_mode_pkg.sv]
package adc_mode_pkg;

    typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_DONE} serial_state_e;

    // decoded controls toward the converter core and output stage
    typedef struct packed {
        logic [1:0] power_state_field;
        logic       output_clock_invert;
        logic [1:0] output_clock_phase_field;
        logic       duty_stabilizer_enable;
        logic [2:0] drive_current_field;
        logic       internal_termination_enable;
        logic       drive_current_double;
        logic       output_disable;
        logic [1:0] output_format_field;
        logic       alternate_bit_polarity;
        logic       scrambler_enable;
        logic       signed_format_select;
    } mode_ctrl_s;

    // one conversion result with its overrange flag
    typedef struct packed {
        logic        overrange_flag;
        logic [15:0] sample_word_bits;
    } sample_s;

endpackage : adc_mode_pkg

// [src/dual_adc_mode_registers.sv]
`timescale 1ns/100ps
`include "adc_mode_map.svh"
// Notes on behaviour
// (RULE1) power field bits 1-0: normal, channel two nap, both nap, full sleep.
// (RULE2) power register bits 7-2 change nothing.
// (RULE3) timing bit 3 inverts the output clock pair.
// (RULE4) timing bits 2-1 delay the output clock by 0, 1/8, 1/4, 3/8 period.
// (RULE5) host must enable the duty stabilizer when any clock phase delay is used.
// (RULE6) timing bit 0 switches the duty cycle stabilizer.
// (RULE7) driver bits 6-4 pick drive current; code 011 unused.
// (RULE8) driver bit 3 enables termination and doubles drive current.
// (RULE9) driver bit 2 set disables the digital outputs.
// (RULE10) host should nap or sleep the device when outputs are disabled.
// (RULE11) driver bits 1-0 pick output interface; code 11 unused.
// (RULE12) pattern codes 000 normal, 001 all zero, 011 all one.
// (RULE13) pattern 101 alternates checkerboard words each sample.
// (RULE14) pattern 111 alternates all zeros and all ones each sample.
// (RULE15) host writes only pattern codes 000, 001, 011, 101, 111.
// (RULE16) format bit 2 enables alternate bit polarity and forces offset binary.
// (RULE17) format bit 1 switches the output randomizer.
// (RULE18) format bit 0 clear gives offset binary results.
// (RULE19) format bit 0 set gives two's complement unless polarity mode overrides.
// (RULE20) software reset clears all mode registers, sleeps briefly, bit self-clears.
// (RULE21) serial word: read flag, seven address bits, eight data bits, MSB first.
// (RULE22) a read returns register data, leaves it unchanged, ignores incoming data.
// (RULE23) unused bits read zero; unused codes give defined behaviour.
module dual_adc_mode_registers
    import adc_mode_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       sdi,
    output logic            sdo_o,
    output logic            sdo_oe,
    input  wire logic       sample_valid,
    input  wire sample_s    sample_in,
    output mode_ctrl_s      mode_ctrl,
    output sample_s         data_out,
    output logic            data_out_valid
);

    // ==========================================================
    // pin synchronisers
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] sdi_sync_r;
    logic       sck_prev_r;

    // two flops per pin before anything looks at the level
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_sync_r  <= 2'h3;
            sck_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            sck_prev_r <= 1'b0;
        end
        else
        begin
            cs_sync_r  <= {cs_sync_r[0], cs_n};
            sck_sync_r <= {sck_sync_r[0], sck};
            sdi_sync_r <= {sdi_sync_r[0], sdi};
            sck_prev_r <= sck_sync_r[1];
        end
    end

    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    assign cs_act   = ~cs_sync_r[1];
    assign sck_rise = sck_sync_r[1] & ~sck_prev_r;
    assign sck_fall = ~sck_sync_r[1] & sck_prev_r;

    // ==========================================================
    // serial word capture
    serial_state_e state_r;
    logic [4:0]    bit_cnt_r;
    logic [15:0]   shift_r;
    logic          commit;
    logic          is_read;

    // the 16th rising edge completes the word; later edges are ignored
    // a word cut short by select going high in the same cycle is dropped
    assign commit  = (state_r == SER_SHIFT) && cs_act && sck_rise && (bit_cnt_r == `WORD_BITS - 5'd1);
    assign is_read = shift_r[14];

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r   <= SER_IDLE;
            bit_cnt_r <= 5'h0;
            shift_r   <= 16'h0;
        end
        else
        begin
            case (state_r)
                SER_IDLE:
                begin
                    bit_cnt_r <= 5'h0;
                    if (cs_act)
                        state_r <= SER_SHIFT;
                end
                SER_SHIFT:
                begin
                    if (!cs_act)
                        state_r <= SER_IDLE;
                    else if (sck_rise)
                    begin
                        shift_r   <= {shift_r[14:0], sdi_sync_r[1]}; // [RULE21]
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        if (commit)
                            state_r <= SER_DONE;
                    end
                end
                SER_DONE:
                begin
                    if (!cs_act)
                        state_r <= SER_IDLE;
                end
                default: state_r <= SER_IDLE;
            endcase
        end
    end

    // ==========================================================
    // mode registers
    logic [7:0] pwr_r;
    logic [7:0] tim_r;
    logic [7:0] drv_r;
    logic [7:0] fmt_r;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_go;
    logic       swrst_go;
    logic [3:0] sleep_cnt_r;

    assign wr_addr  = shift_r[13:7];
    assign wr_data  = {shift_r[6:0], sdi_sync_r[1]};
    assign wr_go    = commit && !shift_r[14]; // [RULE22]
    assign swrst_go = wr_go && (wr_addr == `ADDR_RESET) && wr_data[`SWRST_BIT];

    // reset bit is never stored, so it reads back zero once done
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr_r <= `REG_RESET_VAL;
            tim_r <= `REG_RESET_VAL;
            drv_r <= `REG_RESET_VAL;
            fmt_r <= `REG_RESET_VAL;
        end
        else if (swrst_go)
        begin
            pwr_r <= `REG_RESET_VAL; // [RULE20]
            tim_r <= `REG_RESET_VAL;
            drv_r <= `REG_RESET_VAL;
            fmt_r <= `REG_RESET_VAL;
        end
        else if (wr_go)
        begin
            // unused bits are masked off so they cannot reach the core
            case (wr_addr)
                `ADDR_POWER:  pwr_r <= wr_data & `POWER_MASK; // [RULE2] [RULE23]
                `ADDR_TIMING: tim_r <= wr_data & `TIMING_MASK;
                `ADDR_DRIVER: drv_r <= wr_data & `DRIVER_MASK;
                `ADDR_FORMAT: fmt_r <= wr_data & `FORMAT_MASK;
                default:      ;
            endcase
        end
    end

    // brief sleep after a software reset
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            sleep_cnt_r <= 4'h0;
        else if (swrst_go)
            sleep_cnt_r <= 4'(`SWRST_SLEEP_CYC); // [RULE20]
        else if (sleep_cnt_r != 4'h0)
            sleep_cnt_r <= sleep_cnt_r - 4'h1;
    end

    function automatic logic [7:0] reg_read(input logic [6:0] addr);
        case (addr)
            `ADDR_POWER:  reg_read = pwr_r;
            `ADDR_TIMING: reg_read = tim_r;
            `ADDR_DRIVER: reg_read = drv_r;
            `ADDR_FORMAT: reg_read = fmt_r;
            default:      reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // ==========================================================
    // read-back on the open-drain output
    logic [7:0] rd_shift_r;
    logic       rd_act_r;
    logic       sdo_oe_r;

    // header done at the 8th rising edge; bits leave on falling edges
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_shift_r <= 8'h00;
            rd_act_r   <= 1'b0;
            sdo_oe_r   <= 1'b0;
        end
        else if (!cs_act)
        begin
            rd_act_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else if (state_r == SER_SHIFT && sck_rise && bit_cnt_r == `HEADER_BITS - 5'd1)
        begin
            rd_act_r   <= shift_r[6]; // [RULE22]
            rd_shift_r <= reg_read(shift_r[5:0] == 6'h00 ? {shift_r[5:0], sdi_sync_r[1]}
                                                         : {shift_r[5:0], sdi_sync_r[1]});
        end
        else if (rd_act_r && sck_fall && bit_cnt_r >= `HEADER_BITS && bit_cnt_r < `WORD_BITS)
        begin
            sdo_oe_r   <= ~rd_shift_r[7]; // pull low only for zero bits
            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
        end
    end

    assign sdo_o  = 1'b0;
    assign sdo_oe = sdo_oe_r;

    // ==========================================================
    // decoded controls
    mode_ctrl_s ctrl_r;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_r <= '0;
        else
        begin
            ctrl_r.power_state_field <= (sleep_cnt_r != 4'h0) ? `PWR_SLEEP : pwr_r[1:0]; // [RULE1] [RULE20]
            ctrl_r.output_clock_invert      <= tim_r[3]; // [RULE3]
            ctrl_r.output_clock_phase_field <= tim_r[2:1]; // [RULE4]
            ctrl_r.duty_stabilizer_enable   <= tim_r[0]; // [RULE6]
            // the unused current code falls back to the default drive
            ctrl_r.drive_current_field <= (drv_r[6:4] == `DRV_UNUSED) ? 3'h0 : drv_r[6:4]; // [RULE7] [RULE23]
            ctrl_r.internal_termination_enable <= drv_r[3]; // [RULE8]
            ctrl_r.drive_current_double        <= drv_r[3]; // [RULE8]
            ctrl_r.output_disable              <= drv_r[2]; // [RULE9]
            ctrl_r.output_format_field <= (drv_r[1:0] == `FMT_UNUSED) ? 2'h0 : drv_r[1:0]; // [RULE11] [RULE23]
            ctrl_r.alternate_bit_polarity <= fmt_r[2]; // [RULE16]
            ctrl_r.scrambler_enable       <= fmt_r[1]; // [RULE17]
            ctrl_r.signed_format_select   <= fmt_r[0] & ~fmt_r[2]; // [RULE16] [RULE18] [RULE19]
        end
    end

    assign mode_ctrl = ctrl_r;

    // ==========================================================
    // output word source and format
    sample_s out_r;
    logic    out_vld_r;
    logic    phase_r;

    // pattern phase flips once per sample so alternation tracks the data rate
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_r     <= '0;
            out_vld_r <= 1'b0;
            phase_r   <= 1'b0;
        end
        else
        begin
            out_vld_r <= sample_valid & ~ctrl_r.output_disable; // [RULE9]
            if (sample_valid)
            begin
                phase_r <= ~phase_r;
                if (ctrl_r.output_disable)
                    out_r <= '0;
                else
                    case (fmt_r[5:3])
                        `TP_ZEROS:     out_r <= '0; // [RULE12]
                        `TP_ONES:      out_r <= '1; // [RULE12]
                        `TP_CHECKER:   out_r <= phase_r ? `CHECKER_B : `CHECKER_A; // [RULE13]
                        `TP_ALTERNATE: out_r <= phase_r ? '1 : '0; // [RULE14]
                        default:
                        begin
                            // unused codes behave as normal data
                            out_r.overrange_flag   <= sample_in.overrange_flag;
                            out_r.sample_word_bits <= ctrl_r.signed_format_select
                                ? sample_in.sample_word_bits ^ `SIGN_FLIP // [RULE19]
                                : sample_in.sample_word_bits; // [RULE18]
                        end
                    endcase
            end
        end
    end

    assign data_out       = out_r;
    assign data_out_valid = out_vld_r;

    // ==========================================================
    // assertions
    sequence s_swrst_write;
        swrst_go;
    endsequence

    sequence s_sleep_hold;
        (ctrl_r.power_state_field == `PWR_SLEEP) [*2];
    endsequence

    AST_SWRST_CLEARS: assert property (@(posedge clock) disable iff (sys_rst) // [RULE20]
        s_swrst_write |=> (pwr_r == 8'h00 && tim_r == 8'h00 && drv_r == 8'h00 && fmt_r == 8'h00))
        else $error("software reset left a mode register set");

    AST_SWRST_SLEEP: assert property (@(posedge clock) disable iff (sys_rst) // [RULE20]
        s_swrst_write |=> ##1 s_sleep_hold)
        else $error("no sleep after software reset");

    AST_READ_NO_UPDATE: assert property (@(posedge clock) disable iff (sys_rst) // [RULE22]
        (commit && shift_r[14]) |=> ($stable(pwr_r) && $stable(tim_r) && $stable(drv_r) && $stable(fmt_r)))
        else $error("read access changed a register");

    AST_POWER_FOLLOWS: assert property (@(posedge clock) disable iff (sys_rst) // [RULE1]
        (sleep_cnt_r == 4'h0) |=> (ctrl_r.power_state_field == $past(pwr_r[1:0])))
        else $error("power state differs from register");

    AST_DRIVE_DEFINED: assert property (@(posedge clock) disable iff (sys_rst) // [RULE23]
        (ctrl_r.drive_current_field != `DRV_UNUSED) && (ctrl_r.output_format_field != `FMT_UNUSED))
        else $error("unused code reached the output stage");

    AST_SIGNED_DATA: assert property (@(posedge clock) disable iff (sys_rst) // [RULE19]
        (sample_valid && fmt_r[5:3] == `TP_NORMAL && !ctrl_r.output_disable && ctrl_r.signed_format_select)
        |=> (out_r.sample_word_bits == ($past(sample_in.sample_word_bits) ^ `SIGN_FLIP)))
        else $error("two's complement conversion wrong");

    AST_CHECKER: assert property (@(posedge clock) disable iff (sys_rst) // [RULE13]
        (sample_valid && fmt_r[5:3] == `TP_CHECKER && !ctrl_r.output_disable)
        |=> (out_r == `CHECKER_A || out_r == `CHECKER_B) && (out_r != $past(out_r)))
        else $error("checkerboard pattern wrong");

    AST_SDO_RELEASE: assert property (@(posedge clock) disable iff (sys_rst) // [RULE22]
        (!cs_act || !rd_act_r) |=> !sdo_oe_r)
        else $error("serial output driven outside a read");

endmodule : dual_adc_mode_registers

// [verification/dual_adc_mode_registers_bench.sv]
`timescale 1ns/100ps
// ========
// register bank bench: serial frames plus sample path
module dual_adc_mode_registers_bench
    import adc_mode_pkg::*;
;
    logic        clock;
    logic        sys_rst;
    logic        sample_valid;
    sample_s     sample_in;
    logic        cs_n;
    logic        sck;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe;
    wire logic   sdo_line;
    mode_ctrl_s  mode_ctrl;
    sample_s     data_out;
    logic        data_out_valid;
    int          err_total = 0;
    int          cmp_count = 0;
    int          sleep_hits = 0;
    int          hits0;
    logic [7:0]  shadow [1:4];
    logic [7:0]  rd;
    sample_s     got_a;
    sample_s     got_b;
    logic        vld;
    int          i;
    int          k;
    logic [7:0]  fmt_tab [0:5] = '{8'h00, 8'h01, 8'h05, 8'h08, 8'h18, 8'h07};
    logic [16:0] exp_tab [0:5] = '{17'h12345, 17'h1A345, 17'h12345, 17'h00000, 17'h1FFFF, 17'h12345};

    // open-drain readback with its pull-up
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    dual_adc_mode_registers i_dual_adc_mode_registers
    (
        .clock          (clock),
        .sys_rst        (sys_rst),
        .cs_n           (cs_n),
        .sck            (sck),
        .sdi            (sdi),
        .sdo_o          (sdo_o),
        .sdo_oe         (sdo_oe),
        .sample_valid   (sample_valid),
        .sample_in      (sample_in),
        .mode_ctrl      (mode_ctrl),
        .data_out       (data_out),
        .data_out_valid (data_out_valid)
    );

    serial_host_model i_serial_host_model
    (
        .clock    (clock),
        .sdo_line (sdo_line),
        .cs_n     (cs_n),
        .sck      (sck),
        .sdi      (sdi)
    );

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // the sleep pulse of a software reset is short, so count sleep cycles
    always @(posedge clock)
    begin
        if (mode_ctrl.power_state_field === 2'h3)
        begin
            sleep_hits <= sleep_hits + 1;
        end
    end

    // ========
    // tasks
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic check(input string nm, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        i_serial_host_model.transfer({1'b0, addr, data}, unused);
    endtask : reg_write

    // data bits of a read are set on purpose: they must be ignored
    task automatic reg_read(input logic [6:0] addr, output logic [7:0] data);
        i_serial_host_model.transfer({1'b1, addr, 8'hA5}, data);
    endtask : reg_read

    // unused positions are kept as zero in the expected copy
    task automatic set_reg(input int a, input logic [7:0] data);
        logic [7:0] used;
        used = (a == 1) ? 8'h03 : (a == 2) ? 8'h0F : (a == 3) ? 8'h7F : 8'h3F;
        shadow[a] = data & used;
        reg_write(a[6:0], data);
    endtask : set_reg

    // unused drive and format codes fall back to code zero
    function automatic mode_ctrl_s expect_mode();
        logic [2:0] drv;
        logic [1:0] fmt;
        drv = (shadow[3][6:4] == 3'h3) ? 3'h0 : shadow[3][6:4];
        fmt = (shadow[3][1:0] == 2'h3) ? 2'h0 : shadow[3][1:0];
        return {shadow[1][1:0], shadow[2][3:0], drv, shadow[3][3], shadow[3][3:2], fmt,
                shadow[4][2:1], shadow[4][0] & ~shadow[4][2]};
    endfunction : expect_mode

    task automatic verify_regs();
        for (k = 1; k < 5; k++)
        begin
            reg_read(k[6:0], rd);
            check("reg", {9'h0, shadow[k]}, {9'h0, rd});
        end
        check("mode", expect_mode(), mode_ctrl);
    endtask : verify_regs

    task automatic push_sample(input sample_s s, output sample_s q, output logic v);
        sample_in    = s;
        sample_valid = 1'b1;
        step(1);
        // valid stands for one cycle only, so take it right after the launching edge
        q = data_out;
        v = data_out_valid;
        sample_valid = 1'b0;
        step(1);
    endtask : push_sample

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if ((err_total == 0) && (cmp_count > 0))
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ========
    // main sequence
    initial
    begin
        sys_rst      = 1'b1;
        sample_valid = 1'b0;
        sample_in    = '0;
        for (k = 1; k < 5; k++)
        begin
            shadow[k] = 8'h00;
        end
        step(12);
        sys_rst = 1'b0;
        step(4);
        verify_regs();
        // every code of each field except pattern and output disable, at least once; one pass runs the link slowly
        for (i = 0; i < 8; i++)
        begin
            i_serial_host_model.half_clks = (i == 6) ? 6 : 4;
            set_reg(1, {6'h2A, i[1:0]});
            set_reg(2, {4'hF, i[2], i[1:0], (i[1:0] != 2'h0) | i[2]});
            set_reg(3, {1'b1, i[2:0], i[0], 1'b0, i[1:0]});
            set_reg(4, {2'h3, 3'h0, i[2:0]});
            verify_regs();
        end
        i_serial_host_model.half_clks = 4;
        reg_write(7'h05, 8'hFF);
        reg_read(7'h05, rd);
        check("unmapped", 17'h0, {9'h0, rd});
        verify_regs();
        set_reg(1, 8'h00);
        set_reg(3, 8'h01);
        for (i = 0; i < 6; i++)
        begin
            set_reg(4, fmt_tab[i]);
            push_sample(17'h12345, got_a, vld);
            check("dout", exp_tab[i], got_a);
            check("vld", 17'h1, {16'h0, vld});
        end
        set_reg(4, 8'h28);
        push_sample(17'h12345, got_a, vld);
        push_sample(17'h12345, got_b, vld);
        check("checker", 17'h1, {16'h0, ((got_a === 17'h15555) && (got_b === 17'h0AAAA))
                                       || ((got_a === 17'h0AAAA) && (got_b === 17'h15555))});
        set_reg(4, 8'h38);
        push_sample(17'h12345, got_a, vld);
        push_sample(17'h12345, got_b, vld);
        check("alternate", 17'h1, {16'h0, ((got_a === 17'h00000) && (got_b === 17'h1FFFF))
                                         || ((got_a === 17'h1FFFF) && (got_b === 17'h00000))});
        set_reg(1, 8'h02);
        set_reg(3, 8'h04);
        set_reg(4, 8'h00);
        push_sample(17'h12345, got_a, vld);
        check("vld off", 17'h0, {16'h0, vld});
        check("dout off", 17'h0, got_a);
        set_reg(1, 8'h01);
        set_reg(2, 8'h05);
        hits0 = sleep_hits;
        reg_write(7'h00, 8'h80);
        step(10);
        check("sleep", 17'h1, {16'h0, (sleep_hits - hits0) > 0});
        for (k = 1; k < 5; k++)
        begin
            shadow[k] = 8'h00;
        end
        verify_regs();
        reg_read(7'h00, rd);
        check("rst bit", 17'h0, {9'h0, rd});
        give_verdict();
    end

    // about 14k clocks of traffic are expected; far beyond that is a hang
    initial
    begin
        repeat (60000) @(posedge clock);
        err_total++;
        give_verdict();
    end
endmodule : dual_adc_mode_registers_bench

// [verification/serial_host_model.sv]
`timescale 1ns/100ps
// ========
// host side of the serial configuration port
module serial_host_model
(
    input  wire logic clock,
    input  wire logic sdo_line,
    output logic      cs_n,
    output logic      sck,
    output logic      sdi
);
    // half period of sck in system clocks; 4 gives the 200 ns link clock
    int half_clks = 4;

    // sck parks low and select high between frames
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end

    // every change lands just after a system clock edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // one word, msb first; sdi only moves while sck is low
    task automatic transfer(input logic [15:0] word, output logic [7:0] rdata);
        int i;
        rdata = 8'h00;
        cs_n  = 1'b0;
        step(half_clks);
        for (i = 15; i >= 0; i--)
        begin
            sdi = word[i];
            step(half_clks);
            if (i < 8)
            begin
                rdata[i] = sdo_line; // settled since the previous fall
            end
            sck = 1'b1;
            step(half_clks);
            sck = 1'b0;
        end
        step(half_clks);
        cs_n = 1'b1;
        sdi  = ~sdi; // released line must not keep a stale level
        step(8);
    endtask : transfer
endmodule : serial_host_model
